// ===== inc/iovr_pkg.sv
`default_nettype none
package iovr_pkg;

  // ===========================================================
  // bus addressing
  // ===========================================================
  // arbitrary value, change to suit the board
  localparam logic [6:0] DEV_ADDR         = 7'h5A;

  localparam logic [7:0] ADDR_BOV_LOW     = 8'h06;
  localparam logic [7:0] ADDR_BOV_HIGH    = 8'h07;
  localparam logic [7:0] ADDR_IVL_LOW     = 8'h0A;
  localparam logic [7:0] ADDR_IVL_HIGH    = 8'h0B;
  localparam logic [7:0] ADDR_IIN_RB_LOW  = 8'h24;
  localparam logic [7:0] ADDR_OFFS_CTRL   = 8'h34;

  localparam logic [7:0] READ_UNMAPPED    = 8'h00;
  localparam logic [7:0] RESET_BYTE       = 8'h00;
  localparam logic [3:0] BITS_PER_BYTE    = 4'h8;

  // ===========================================================
  // field layout
  // ===========================================================
  localparam int HIGH_RSVD_MSB    = 7;
  localparam int HIGH_RSVD_LSB    = 6;
  localparam int IVL_HI_MSB       = 5;
  localparam int IVL_LO_MSB       = 7;
  localparam int IVL_LO_LSB       = 6;
  localparam int BOV_HI_MSB       = 5;
  localparam int BOV_LO_MSB       = 7;
  localparam int BOV_LO_LSB       = 2;
  localparam int OFFS_DIS_BIT     = 2;

  localparam logic [5:0]  RESET_IVL_HI    = 6'h00;
  localparam logic [1:0]  RESET_IVL_LO    = 2'h0;
  localparam logic [11:0] RESET_BOV       = 12'h000;
  localparam logic [5:0]  RESET_BOV_STAGE = 6'h00;
  localparam logic        RESET_OFFS_DIS  = 1'b0;

  // ===========================================================
  // input voltage limit scaling, millivolts
  // ===========================================================
  localparam logic [15:0] IVL_OFFSET_MV   = 16'h0C80;
  localparam logic [15:0] IVL_DROP_MV     = 16'h0500;
  localparam int          IVL_LSB_SHIFT   = 6;
  localparam logic [7:0]  IVL_CODE_MAX    = 8'hFF;

  // ===========================================================
  // boost setpoint scaling, tenths of a millivolt
  // ===========================================================
  localparam int BOV_BITS = 12;
  localparam logic [19:0] BOV_WEIGHT_DMV [BOV_BITS] = '{
    20'h00051, 20'h000A0, 20'h0014A, 20'h0028A, 20'h00514, 20'h00A28,
    20'h0145A, 20'h028AA, 20'h05154, 20'h0A2A8, 20'h14550, 20'h28AA0};
  localparam logic [19:0] BOV_OFFSET_DMV  = 20'h03200;
  localparam logic [19:0] BOV_MIN_DMV     = 20'h07530;
  localparam logic [19:0] BOV_MAX_DMV     = 20'h32C80;

  typedef enum logic [3:0] {
    st_idle, st_addr, st_addr_ack, st_reg, st_reg_ack,
    st_wdata, st_wdata_ack, st_rdata, st_rdata_ack
  } iovr_bus_st_type;

endpackage
`default_nettype wire

// ===== src/iovr_boost_check.sv
`timescale 1ns/1ps
`default_nettype none
module iovr_boost_check (
  input  wire logic [11:0] code,
  input  wire logic        offset_disable,
  output logic      [19:0] total_dmv,
  output logic             in_range
);

  // ===========================================================
  // weighted sum of the set code bits
  // ===========================================================
  logic [19:0] term [iovr_pkg::BOV_BITS];

  genvar g;
  generate
    for (g = 0; g < iovr_pkg::BOV_BITS; g = g + 1) begin : g_term
      assign term[g] = code[g] ? iovr_pkg::BOV_WEIGHT_DMV[g] : 20'h00000;
    end
  endgenerate

  always_comb begin
    total_dmv = offset_disable ? 20'h00000 : iovr_pkg::BOV_OFFSET_DMV;
    for (int i = 0; i < iovr_pkg::BOV_BITS; i++) begin
      total_dmv = total_dmv + term[i];
    end
    in_range = (total_dmv >= iovr_pkg::BOV_MIN_DMV) &&
               (total_dmv <= iovr_pkg::BOV_MAX_DMV);
  end

endmodule // iovr_boost_check
`default_nettype wire

// ===== src/iovr_regs.sv
// Operation
// - input limit is 16 bits at 0x0B/0x0A
// - input field 8 bits, 64 mV lsb
// - input code zero means 3.2 V
// - input below limit enters input regulation
// - input limit resets to bus minus 1.28 V
// - reserved input bits and readback read zero
// - boost setpoint at 0x07/0x06, resets zero
// - boost field 12 bits, 16 mV bit1
// - out-of-range boost writes are discarded
// - 0x34 bit 2 removes 1.28 V offset
// - boost bit0 at low bit 2; 1:0 ignored
`timescale 1ns/1ps
`default_nettype none
module iovr_regs (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_n,
  input  wire logic [15:0] vbus_noload_mv,
  input  wire logic [15:0] vbus_mv,
  output logic      [7:0]  input_voltage_limit_code,
  output logic      [11:0] boost_output_voltage_code,
  output logic             boost_offset_disable,
  output logic             input_regulation_state
);

  // ===========================================================
  // state
  // ===========================================================
  typedef struct packed {
    logic                      scl_s1;
    logic                      scl_s2;
    logic                      scl_p;
    logic                      sda_s1;
    logic                      sda_s2;
    logic                      sda_p;
    iovr_pkg::iovr_bus_st_type st;
    logic [3:0]                bitcnt;
    logic [7:0]                shreg;
    logic [7:0]                tx;
    logic [7:0]                ptr;
    logic                      rd;
    logic                      mack;
    logic                      sda_out;
    logic                      sda_oe_n;
    logic [5:0]                ivl_hi;
    logic [1:0]                ivl_lo;
    logic [11:0]               bov;
    logic [5:0]                bov_stage;
    logic                      offs_dis;
    logic                      init_done;
    logic                      inreg;
  } iovr_state_type;

  iovr_state_type state_ff;
  iovr_state_type nxt_state;

  logic [19:0] cand_dmv;
  logic        cand_ok;
  logic [11:0] cand_code;

  // a boost update is judged as the whole 12-bit code, staged low
  // byte plus incoming high byte
  assign cand_code = {state_ff.shreg[iovr_pkg::BOV_HI_MSB:0],
                      state_ff.bov_stage};

  iovr_boost_check u_check (
    .code           (cand_code),
    .offset_disable (state_ff.offs_dis),
    .total_dmv      (cand_dmv),
    .in_range       (cand_ok)
  );

  // ===========================================================
  // read decode
  // ===========================================================
  function automatic logic [7:0] read_byte(input iovr_state_type s,
                                           input logic [7:0] a);
    logic [7:0] r;
    r = iovr_pkg::READ_UNMAPPED;
    case (a)
      iovr_pkg::ADDR_BOV_LOW:
        r = {s.bov[5:0], 2'h0};
      iovr_pkg::ADDR_BOV_HIGH:
        r = {2'h0, s.bov[11:6]};
      iovr_pkg::ADDR_IVL_LOW:
        r = {s.ivl_lo, 6'h00};
      iovr_pkg::ADDR_IVL_HIGH:
        r = {2'h0, s.ivl_hi};
      iovr_pkg::ADDR_IIN_RB_LOW:
        r = iovr_pkg::RESET_BYTE;
      iovr_pkg::ADDR_OFFS_CTRL:
        r = {5'h00, s.offs_dis, 2'h0};
      default:
        r = iovr_pkg::READ_UNMAPPED;
    endcase
    return r;
  endfunction

  // ===========================================================
  // reset default of the input limit
  // ===========================================================
  function automatic logic [7:0] default_ivl(input logic [15:0] vb);
    logic [15:0] base;
    logic [15:0] diff;
    logic [15:0] code;
    base = iovr_pkg::IVL_OFFSET_MV + iovr_pkg::IVL_DROP_MV;
    diff = 16'h0000;
    code = 16'h0000;
    if (vb > base) begin
      diff = vb - base;
      code = diff >> iovr_pkg::IVL_LSB_SHIFT;
    end
    if (code > {8'h00, iovr_pkg::IVL_CODE_MAX}) begin
      return iovr_pkg::IVL_CODE_MAX;
    end
    return code[7:0];
  endfunction

  // ===========================================================
  // next state
  // ===========================================================
  always_comb begin
    logic        scl_rise;
    logic        scl_fall;
    logic        start_c;
    logic        stop_c;
    logic [7:0]  byte_c;
    logic [15:0] limit_mv;
    logic [7:0]  dflt_c;
    nxt_state = state_ff;
    dflt_c    = 8'h00;
    scl_rise  = 1'b0;
    scl_fall  = 1'b0;
    start_c   = 1'b0;
    stop_c    = 1'b0;
    byte_c    = 8'h00;
    limit_mv  = 16'h0000;

    // two-stage synchronisers, edges taken from the second stage
    nxt_state.scl_s1 = scl_in;
    nxt_state.scl_s2 = state_ff.scl_s1;
    nxt_state.scl_p  = state_ff.scl_s2;
    nxt_state.sda_s1 = sda_in;
    nxt_state.sda_s2 = state_ff.sda_s1;
    nxt_state.sda_p  = state_ff.sda_s2;

    scl_rise = state_ff.scl_s2 & ~state_ff.scl_p;
    scl_fall = ~state_ff.scl_s2 & state_ff.scl_p;
    start_c  = state_ff.scl_s2 & state_ff.scl_p &
               ~state_ff.sda_s2 & state_ff.sda_p;
    stop_c   = state_ff.scl_s2 & state_ff.scl_p &
               state_ff.sda_s2 & ~state_ff.sda_p;

    // the limit is captured from the unloaded bus once, on the first
    // enabled cycle after reset, so a strap-like level is never
    // loaded asynchronously
    if (!state_ff.init_done) begin
      nxt_state.init_done = 1'b1;
      dflt_c              = default_ivl(vbus_noload_mv);
      nxt_state.ivl_hi    = dflt_c[7:2];
      nxt_state.ivl_lo    = dflt_c[1:0];
    end

    // ===========================================================
    // serial bus slave
    // ===========================================================
    if (start_c) begin
      nxt_state.st       = iovr_pkg::st_addr;
      nxt_state.bitcnt   = 4'h0;
      nxt_state.sda_out  = 1'b1;
      nxt_state.sda_oe_n = 1'b1;
    end else if (stop_c) begin
      nxt_state.st       = iovr_pkg::st_idle;
      nxt_state.sda_out  = 1'b1;
      nxt_state.sda_oe_n = 1'b1;
    end else if (scl_rise) begin
      case (state_ff.st)
        iovr_pkg::st_addr, iovr_pkg::st_reg, iovr_pkg::st_wdata: begin
          nxt_state.shreg  = {state_ff.shreg[6:0], state_ff.sda_s2};
          nxt_state.bitcnt = state_ff.bitcnt + 4'h1;
        end
        iovr_pkg::st_rdata: begin
          nxt_state.bitcnt = state_ff.bitcnt + 4'h1;
        end
        iovr_pkg::st_rdata_ack: begin
          nxt_state.mack = ~state_ff.sda_s2;
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      case (state_ff.st)
        iovr_pkg::st_addr: begin
          if (state_ff.bitcnt == iovr_pkg::BITS_PER_BYTE) begin
            if (state_ff.shreg[7:1] == iovr_pkg::DEV_ADDR) begin
              nxt_state.rd       = state_ff.shreg[0];
              nxt_state.sda_out  = 1'b0;
              nxt_state.sda_oe_n = 1'b0;
              nxt_state.st       = iovr_pkg::st_addr_ack;
            end else begin
              nxt_state.st = iovr_pkg::st_idle;
            end
          end
        end
        iovr_pkg::st_addr_ack: begin
          nxt_state.bitcnt = 4'h0;
          if (state_ff.rd) begin
            byte_c             = read_byte(state_ff, state_ff.ptr);
            nxt_state.tx       = byte_c;
            nxt_state.sda_out  = byte_c[7];
            nxt_state.sda_oe_n = byte_c[7];
            nxt_state.st       = iovr_pkg::st_rdata;
          end else begin
            nxt_state.sda_out  = 1'b1;
            nxt_state.sda_oe_n = 1'b1;
            nxt_state.st       = iovr_pkg::st_reg;
          end
        end
        iovr_pkg::st_reg: begin
          if (state_ff.bitcnt == iovr_pkg::BITS_PER_BYTE) begin
            nxt_state.ptr      = state_ff.shreg;
            nxt_state.sda_out  = 1'b0;
            nxt_state.sda_oe_n = 1'b0;
            nxt_state.st       = iovr_pkg::st_reg_ack;
          end
        end
        iovr_pkg::st_wdata: begin
          if (state_ff.bitcnt == iovr_pkg::BITS_PER_BYTE) begin
            nxt_state.ptr      = state_ff.ptr + 8'h01;
            nxt_state.sda_out  = 1'b0;
            nxt_state.sda_oe_n = 1'b0;
            nxt_state.st       = iovr_pkg::st_wdata_ack;
            case (state_ff.ptr)
              iovr_pkg::ADDR_BOV_LOW: begin
                // held until the high byte arrives; bits 1:0 dropped
                nxt_state.bov_stage = state_ff.shreg[
                  iovr_pkg::BOV_LO_MSB:iovr_pkg::BOV_LO_LSB];
              end
              iovr_pkg::ADDR_BOV_HIGH: begin
                // reserved bits set count as an invalid write
                if (state_ff.shreg[iovr_pkg::HIGH_RSVD_MSB:
                                   iovr_pkg::HIGH_RSVD_LSB] == 2'h0 &&
                    cand_ok) begin
                  nxt_state.bov = cand_code;
                end
              end
              iovr_pkg::ADDR_IVL_LOW: begin
                nxt_state.ivl_lo = state_ff.shreg[
                  iovr_pkg::IVL_LO_MSB:iovr_pkg::IVL_LO_LSB];
              end
              iovr_pkg::ADDR_IVL_HIGH: begin
                if (state_ff.shreg[iovr_pkg::HIGH_RSVD_MSB:
                                   iovr_pkg::HIGH_RSVD_LSB] == 2'h0) begin
                  nxt_state.ivl_hi =
                    state_ff.shreg[iovr_pkg::IVL_HI_MSB:0];
                end
              end
              iovr_pkg::ADDR_OFFS_CTRL: begin
                nxt_state.offs_dis =
                  state_ff.shreg[iovr_pkg::OFFS_DIS_BIT];
              end
              default: begin
              end
            endcase
          end
        end
        iovr_pkg::st_reg_ack, iovr_pkg::st_wdata_ack: begin
          nxt_state.bitcnt   = 4'h0;
          nxt_state.sda_out  = 1'b1;
          nxt_state.sda_oe_n = 1'b1;
          nxt_state.st       = iovr_pkg::st_wdata;
        end
        iovr_pkg::st_rdata: begin
          if (state_ff.bitcnt == iovr_pkg::BITS_PER_BYTE) begin
            nxt_state.ptr      = state_ff.ptr + 8'h01;
            nxt_state.sda_out  = 1'b1;
            nxt_state.sda_oe_n = 1'b1;
            nxt_state.st       = iovr_pkg::st_rdata_ack;
          end else begin
            nxt_state.tx       = {state_ff.tx[6:0], 1'b0};
            nxt_state.sda_out  = state_ff.tx[6];
            nxt_state.sda_oe_n = state_ff.tx[6];
          end
        end
        iovr_pkg::st_rdata_ack: begin
          nxt_state.bitcnt = 4'h0;
          if (state_ff.mack) begin
            byte_c             = read_byte(state_ff, state_ff.ptr);
            nxt_state.tx       = byte_c;
            nxt_state.sda_out  = byte_c[7];
            nxt_state.sda_oe_n = byte_c[7];
            nxt_state.st       = iovr_pkg::st_rdata;
          end else begin
            nxt_state.st = iovr_pkg::st_idle;
          end
        end
        default: begin
        end
      endcase
    end

    // ===========================================================
    // input regulation
    // ===========================================================
    // limit = 3200 mV + code * 64 mV, never above 19520 mV
    limit_mv = iovr_pkg::IVL_OFFSET_MV +
               ({8'h00, state_ff.ivl_hi, state_ff.ivl_lo}
                << iovr_pkg::IVL_LSB_SHIFT);
    nxt_state.inreg = state_ff.init_done && (vbus_mv < limit_mv);
  end

  // ===========================================================
  // registers
  // ===========================================================
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_ff           <= '0;
      state_ff.st        <= iovr_pkg::st_idle;
      state_ff.scl_s1    <= 1'b1;
      state_ff.scl_s2    <= 1'b1;
      state_ff.scl_p     <= 1'b1;
      state_ff.sda_s1    <= 1'b1;
      state_ff.sda_s2    <= 1'b1;
      state_ff.sda_p     <= 1'b1;
      state_ff.sda_out   <= 1'b1;
      state_ff.sda_oe_n  <= 1'b1;
      state_ff.ivl_hi    <= iovr_pkg::RESET_IVL_HI;
      state_ff.ivl_lo    <= iovr_pkg::RESET_IVL_LO;
      state_ff.bov       <= iovr_pkg::RESET_BOV;
      state_ff.bov_stage <= iovr_pkg::RESET_BOV_STAGE;
      state_ff.offs_dis  <= iovr_pkg::RESET_OFFS_DIS;
    end else if (ce) begin
      state_ff <= nxt_state;
    end
  end

  assign sda_out                   = state_ff.sda_out;
  assign sda_oe_n                  = state_ff.sda_oe_n;
  assign input_voltage_limit_code  = {state_ff.ivl_hi, state_ff.ivl_lo};
  assign boost_output_voltage_code = state_ff.bov;
  assign boost_offset_disable      = state_ff.offs_dis;
  assign input_regulation_state    = state_ff.inreg;

endmodule // iovr_regs
`default_nettype wire

// ===== bench/iovr_regs_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ====================================
// port checker of the register slice
module iovr_regs_checker (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        ce,
  input wire logic        scl_in,
  input wire logic        sda_in,
  input wire logic        sda_out,
  input wire logic        sda_oe_n,
  input wire logic [15:0] vbus_noload_mv,
  input wire logic [15:0] vbus_mv,
  input wire logic [7:0]  input_voltage_limit_code,
  input wire logic [11:0] boost_output_voltage_code,
  input wire logic        boost_offset_disable,
  input wire logic        input_regulation_state
);
  logic first_done_ff;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) first_done_ff <= 1'b0;
    else if (ce) first_done_ff <= 1'b1;
  end

  function automatic logic [7:0] dflt(input logic [15:0] v);
    logic [15:0] q;
    q = (v - iovr_pkg::IVL_OFFSET_MV - iovr_pkg::IVL_DROP_MV) >> 6;
    if (v <= iovr_pkg::IVL_OFFSET_MV + iovr_pkg::IVL_DROP_MV) return 8'h00;
    return (q > 16'h00FF) ? 8'hFF : q[7:0];
  endfunction

  // tenths of a millivolt, so the 8.1 mV step stays exact
  function automatic logic ok_bov(input logic [11:0] c, input logic d);
    logic [19:0] t;
    t = d ? 20'h00000 : iovr_pkg::BOV_OFFSET_DMV;
    for (int i = 0; i < 12; i++) begin
      if (c[i]) t = t + iovr_pkg::BOV_WEIGHT_DMV[i];
    end
    return t >= iovr_pkg::BOV_MIN_DMV && t <= iovr_pkg::BOV_MAX_DMV;
  endfunction

  // ====================================
  // properties
  property p_reg;
    first_done_ff && ce |=> input_regulation_state ==
      ($past(vbus_mv) < ({8'h00, $past(input_voltage_limit_code)} << 6)
       + iovr_pkg::IVL_OFFSET_MV);
  endproperty
  a_reg: assert property (p_reg)
    else $error("regulation flag wrong");
  property p_dflt;
    !first_done_ff && ce |=>
      input_voltage_limit_code == dflt($past(vbus_noload_mv));
  endproperty
  a_dflt: assert property (p_dflt)
    else $error("limit default wrong");
  property p_rst_val;
    $fell(rst) |-> boost_output_voltage_code == 12'h000 && sda_oe_n;
  endproperty
  a_rst_val: assert property (p_rst_val)
    else $error("reset value wrong");
  property p_bov_rng;
    $changed(boost_output_voltage_code) |->
      ok_bov(boost_output_voltage_code, $past(boost_offset_disable));
  endproperty
  a_bov_rng: assert property (p_bov_rng)
    else $error("boost setpoint out of range");
  property p_bov_chg;
    $changed(boost_output_voltage_code) |-> !scl_in;
  endproperty
  a_bov_chg: assert property (p_bov_chg)
    else $error("boost changed off a write");
  property p_lim_chg;
    $past(first_done_ff) && $changed(input_voltage_limit_code) |-> !scl_in;
  endproperty
  a_lim_chg: assert property (p_lim_chg)
    else $error("limit changed off a write");
  property p_sda;
    sda_out == sda_oe_n && ($changed(sda_oe_n) -> !scl_in);
  endproperty
  a_sda: assert property (p_sda)
    else $error("data line moved while clock high");
  property p_freeze;
    !ce |=> $stable(input_voltage_limit_code)
      && $stable(boost_output_voltage_code) && $stable(sda_oe_n);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("state moved with enable low");
endmodule // iovr_regs_checker

bind iovr_regs iovr_regs_checker i_chk (
  .sys_clk(sys_clk), .rst(rst), .ce(ce), .scl_in(scl_in),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
  .vbus_noload_mv(vbus_noload_mv), .vbus_mv(vbus_mv),
  .input_voltage_limit_code(input_voltage_limit_code),
  .boost_output_voltage_code(boost_output_voltage_code),
  .boost_offset_disable(boost_offset_disable),
  .input_regulation_state(input_regulation_state));
`default_nettype wire

// ===== bench/iovr_host.sv
`timescale 1ns/1ps
`default_nettype none
// ====================================
// host controller: bus master model
module iovr_host (
  input  wire logic sys_clk,
  output var logic  scl,
  output var logic  sda,
  input  wire logic sda_w
);
  int ph = 8;

  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end

  task automatic hp(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // data moves mid-low; sampled before the edge to dodge the flop race
  task automatic bt(input logic b, output logic s);
    scl <= 1'b0;
    hp(ph / 2);
    sda <= b;
    hp(ph - ph / 2);
    scl <= 1'b1;
    hp(ph - 1);
    @(negedge sys_clk);
    s = sda_w;
    @(posedge sys_clk);
  endtask

  // a=1 gives a start, a=0 a stop
  task automatic cond(input logic a);
    @(posedge sys_clk);
    scl <= 1'b0;
    hp(ph / 2);
    sda <= a;
    hp(ph - ph / 2);
    scl <= 1'b1;
    hp(ph);
    sda <= !a;
    hp(ph);
  endtask

  task automatic tx(input logic [7:0] v, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bt(v[i], s);
    bt(1'b1, s);
    ack = !s;
  endtask

  // last byte is always refused, as a one-byte read ends
  task automatic rx(output logic [7:0] v);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bt(1'b1, s);
      v[i] = s;
    end
    bt(1'b1, s);
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] p, d0, d1,
                    input int n, output logic ok);
    logic k0, k1, k2, k3;
    cond(1'b1);
    tx({a, 1'b0}, k0);
    tx(p, k1);
    tx(d0, k2);
    k3 = 1'b1;
    if (n > 1) tx(d1, k3);
    cond(1'b0);
    ok = k0 & k1 & k2 & k3;
  endtask

  task automatic rd(input logic [7:0] p, output logic [7:0] v);
    logic k;
    cond(1'b1);
    tx({iovr_pkg::DEV_ADDR, 1'b0}, k);
    tx(p, k);
    cond(1'b1);
    tx({iovr_pkg::DEV_ADDR, 1'b1}, k);
    rx(v);
    cond(1'b0);
  endtask
endmodule // iovr_host
`default_nettype wire

// ===== bench/iovr_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin \
  n_checks++; \
  if ((a) !== (e)) begin \
    miscompares++; \
    $display("mismatch at %0t: got %h exp %h", $time, a, e); \
  end \
end
// ====================================
// bench of the register slice
module iovr_regs_tb;
  logic        sys_clk;
  logic        rst;
  logic        ce;
  logic        scl;
  logic        hsda;
  logic        sda_oe_n;
  logic        ok;
  logic        ireg;
  logic        bod;
  logic [7:0]  d;
  logic [7:0]  lim;
  logic [11:0] bov;
  logic [15:0] vnl;
  logic [15:0] vbus;
  wire logic   sda_w;
  int          miscompares;
  int          n_checks;

  // open drain with pull-up
  assign sda_w = hsda & sda_oe_n;

  iovr_host i_host (.sys_clk(sys_clk), .scl(scl), .sda(hsda), .sda_w(sda_w));
  iovr_regs i_dut (.sys_clk(sys_clk), .rst(rst), .ce(ce), .scl_in(scl),
    .sda_in(sda_w), .sda_out(), .sda_oe_n(sda_oe_n), .vbus_noload_mv(vnl),
    .vbus_mv(vbus), .input_voltage_limit_code(lim),
    .boost_output_voltage_code(bov), .boost_offset_disable(bod),
    .input_regulation_state(ireg));

  always #5 sys_clk = ~sys_clk;

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic w(input logic [7:0] p, d0, d1, input int n);
    i_host.wr(iovr_pkg::DEV_ADDR, p, d0, d1, n, ok);
    `CHK(ok, 1'b1)
  endtask

  task automatic r(input logic [7:0] p, e);
    i_host.rd(p, d);
    `CHK(d, e)
  endtask

  task automatic bw(input logic [7:0] lo, hi, input logic [11:0] e);
    w(8'h06, lo, hi, 2);
    @(negedge sys_clk);
    `CHK(bov, e)
  endtask

  task automatic rg(input logic [7:0] hi, input logic [15:0] v, input logic e);
    w(8'h0A, 8'h00, hi, 2);
    vbus <= v;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    `CHK(ireg, e)
  endtask

  initial begin
    sys_clk = 1'b0;
    rst = 1'b1;
    ce = 1'b1;
    vnl = 16'h2EE0;
    vbus = 16'h3A98;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    `CHK(lim, 8'h75)
    `CHK(bov, 12'h000)
    r(8'h0B, 8'h1D);
    r(8'h0A, 8'h40);
    r(8'h07, 8'h00);
    r(8'h24, 8'h00);
    r(8'h30, 8'h00);
    w(8'h0A, 8'hFF, 8'h3F, 2);
    r(8'h0A, 8'hC0);
    w(8'h0B, 8'hC5, 8'h00, 1);
    `CHK(lim, 8'hFF)
    rg(8'h00, 16'h0C7F, 1'b1);
    rg(8'h00, 16'h0C80, 1'b0);
    rg(8'h20, 16'h2C7F, 1'b1);
    rg(8'h20, 16'h2C80, 1'b0);
    i_host.wr(7'h5B, 8'h0B, 8'h00, 8'h00, 1, ok);
    `CHK(ok, 1'b0)
    `CHK(lim, 8'h80)
    bw(8'h83, 8'h08, 12'h220);
    bw(8'h80, 8'h01, 12'h220);
    bw(8'hFC, 8'h3F, 12'h220);
    bw(8'h00, 8'hC8, 12'h220);
    w(8'h34, 8'h04, 8'h00, 1);
    `CHK(bod, 1'b1)
    bw(8'h00, 8'h02, 12'h220);
    bw(8'h00, 8'h28, 12'h220);
    // a slow host must be served just the same
    i_host.ph = 20;
    bw(8'h00, 8'h24, 12'h900);
    i_host.ph = 8;
    w(8'h34, 8'h00, 8'h00, 1);
    bw(8'h00, 8'h04, 12'h100);
    r(8'h07, 8'h04);
    ce <= 1'b0;
    vbus <= 16'h0000;
    repeat (5) @(posedge sys_clk);
    `CHK(ireg, 1'b0)
    ce <= 1'b1;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    `CHK(ireg, 1'b1)
    vnl <= 16'hFFFF;
    rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    `CHK(lim, 8'hFF)
    `CHK(bov, 12'h000)
    complete_run();
  end

  initial begin
    repeat (100000) @(posedge sys_clk);
    miscompares++;
    complete_run();
  end
endmodule // iovr_regs_tb
`default_nettype wire
